/* hw/aid_consts.svh */
// constants for the analog input option and diagnostic block
// ===========================================================
// Operation
// - rate code picks conversion rate and resolution
// - rate shared among all active channels
// - bits 5..4 pick selection filter
// - bits 7..6 pick envelope filter
// - alarm enabled error sends four byte record
// - record bytes 2 and 3 sent empty
// - status byte holds fault, external, channel flags
// - class byte holds 0101 and channel flag
// - red channel light on any channel error
// - eight input bytes, one word per channel
// - channels set up alone, each switchable off
// - parameter byte 0 bit 6 gates alarms
// - function number FFh switches channel off
`ifndef AID_CONSTS_SVH
`define AID_CONSTS_SVH

// ===========================================================
// register offsets (byte addresses)
`define AID_OFS_DIAG0     8'h00
`define AID_OFS_DIAG1     8'h01
`define AID_OFS_DIAG2     8'h02
`define AID_OFS_DIAG3     8'h03
`define AID_OFS_OPT0      8'h06
`define AID_OFS_ALARM     8'h0A
`define AID_OFS_FUNC0     8'h0B
`define AID_OFS_DATA0     8'h10
`define AID_OFS_IRQ_ST    8'h18
`define AID_OFS_IRQ_EN    8'h19
`define AID_OFS_IRQ_CLR   8'h1A
`define AID_OFS_ACTIVE    8'h1B

// ===========================================================
// fields and reset values
`define AID_ALARM_BIT     6
`define AID_OPT_RST       8'h00
`define AID_ALARM_RST     8'h00
`define AID_FUNC_RST      8'h28
`define AID_FUNC_OFF      8'hFF
`define AID_FUNC_KEEP     8'h00
`define AID_CLASS_ANALOG  4'h5
`define AID_IRQ_DIAG      0
`define AID_IRQ_DATA      1
`define AID_ENV_SMALL     17'sh00008
`define AID_ENV_LARGE     17'sh00010

// ===========================================================
// timing: rates in milli-conversions per second
`define AID_CLK_HZ        125000000
`define AID_RATE0_MCPS    15000
`define AID_RATE1_MCPS    30000
`define AID_RATE2_MCPS    60000
`define AID_RATE3_MCPS    123000
`define AID_RATE4_MCPS    168000
`define AID_RATE5_MCPS    202000
`define AID_RATE6_MCPS    3700
`define AID_RATE7_MCPS    7500
`define AID_CYC(m)        (int'((64'd1000 * 64'd125000000) / (m)))

`endif

/* hw/aid_pkg.sv */
// types and decode functions for the analog input block
`include "aid_consts.svh"
package aid_pkg;
    // ===========================================================
    // types
    typedef logic [7:0] aid_byte_t;
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'h1,
        ST_WAIT = 3'h2,
        ST_BUSY = 3'h4
    } aid_state_t;

    // ===========================================================
    // option decode; unlisted rate codes fall back to code 0
    function automatic logic [2:0] aid_rate_code(input aid_byte_t opt);
        aid_rate_code = opt[3] ? 3'h0 : opt[2:0];
    endfunction : aid_rate_code

    function automatic logic [4:0] aid_res_bits(input aid_byte_t opt);
        case (aid_rate_code(opt))
            3'h2:    aid_res_bits = 5'h0F;
            3'h3:    aid_res_bits = 5'h0E;
            3'h4:    aid_res_bits = 5'h0C;
            3'h5:    aid_res_bits = 5'h0A;
            default: aid_res_bits = 5'h10;
        endcase
    endfunction : aid_res_bits
endpackage : aid_pkg

/* hw/aid_chan_filter.sv */
// per-channel resolution, selection and envelope filter
`timescale 1ns/1ps
`include "aid_consts.svh"
module aid_chan_filter
(
    // clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             reset_in,
    // sample in
    input  wire logic             sample_valid_in,
    input  wire logic [15:0]      sample_in,
    input  wire aid_pkg::aid_byte_t option_in,
    // filtered word out
    output logic      [15:0]      value_out,
    output logic                  update_out
);
    import aid_pkg::*;

    // ===========================================================
    // decode
    logic [2:0]  sel_cnt_q;
    logic [15:0] value_q;
    logic        update_q;
    wire  [4:0]  res_bits  = aid_res_bits(option_in);
    wire  [15:0] res_mask  = 16'hFFFF << (5'h10 - res_bits);
    wire  [15:0] masked    = sample_in & res_mask;
    wire  [1:0]  sel_mode  = option_in[5:4];
    wire  [2:0]  sel_len   = (sel_mode == 2'h1) ? 3'h3 : 3'h6;
    wire  [2:0]  sel_keep  = (sel_mode == 2'h1) ? 3'h2 : 3'h4;
    wire         sel_on    = (sel_mode == 2'h1) || (sel_mode == 2'h2);
    wire         sel_pass  = !sel_on || (sel_cnt_q < sel_keep);
    wire  [2:0]  sel_next  = (sel_cnt_q + 3'h1 >= sel_len) ? 3'h0 : sel_cnt_q + 3'h1;
    wire  signed [16:0] diff = $signed({masked[15], masked}) - $signed({value_q[15], value_q});
    wire  signed [16:0] mag  = diff[16] ? -diff : diff;
    // small moves inside the envelope are held back to quiet noise
    wire  signed [16:0] env  = (option_in[7:6] == 2'h1) ? `AID_ENV_SMALL : `AID_ENV_LARGE;
    wire         env_on    = (option_in[7:6] == 2'h1) || (option_in[7:6] == 2'h2);
    wire         env_pass  = !env_on || (mag > env);
    wire         take      = sample_valid_in && sel_pass && env_pass;

    // ===========================================================
    // state
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            sel_cnt_q <= 3'h0;
            value_q   <= 16'h0000;
            update_q  <= 1'b0;
        end
        else
        begin
            if (sample_valid_in)
                sel_cnt_q <= sel_on ? sel_next : 3'h0;
            if (take)
                value_q <= masked;
            update_q <= take;
        end
    end

    assign value_out  = value_q;
    assign update_out = update_q;
endmodule : aid_chan_filter

/* hw/aid_option_diag.sv */
// four-channel analog input option decode, scheduler and diagnostics
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
`include "aid_consts.svh"
module aid_option_diag
#(
    parameter int unsigned CONV_CYC [8] = '{`AID_CYC(`AID_RATE0_MCPS),
                                            `AID_CYC(`AID_RATE1_MCPS),
                                            `AID_CYC(`AID_RATE2_MCPS),
                                            `AID_CYC(`AID_RATE3_MCPS),
                                            `AID_CYC(`AID_RATE4_MCPS),
                                            `AID_CYC(`AID_RATE5_MCPS),
                                            `AID_CYC(`AID_RATE6_MCPS),
                                            `AID_CYC(`AID_RATE7_MCPS)}
)
(
    // clock and reset
    input  wire logic               core_clk_in,
    input  wire logic               reset_in,
    // register port
    input  wire logic [7:0]         reg_addr_in,
    input  wire aid_pkg::aid_byte_t reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output aid_pkg::aid_byte_t      reg_rdata_out,
    // converter front end
    output logic                    conv_start_out,
    output logic [1:0]              conv_chan_out,
    input  wire logic               conv_done_in,
    input  wire logic [15:0]        conv_data_in,
    // error sources
    input  wire logic               module_fault_in,
    input  wire logic               ext_error_in,
    input  wire logic [3:0]         chan_error_in,
    // diagnostic record stream
    output logic                    diag_valid_out,
    output aid_pkg::aid_byte_t      diag_data_out,
    output logic                    diag_last_out,
    input  wire logic               diag_ready_in,
    // indicators and interrupt
    output logic [3:0]              channel_error_leds_out,
    output logic                    irq_out
);
    import aid_pkg::*;

    // ===========================================================
    // registers
    aid_byte_t   opt_q [4];
    aid_byte_t   func_q [4];
    aid_byte_t   alarm_q;
    aid_byte_t   diag0_q;
    aid_byte_t   diag1_q;
    aid_byte_t   rdata_q;
    logic [1:0]  irq_st_q;
    logic [1:0]  irq_en_q;
    logic        irq_q;
    logic [3:0]  led_q;
    logic [3:0]  chan_lat_q;
    logic        err_prev_q;
    aid_state_t  state_q;
    aid_state_t  state_d;
    logic [31:0] tmr_q;
    logic [1:0]  chan_q;
    logic        start_q;
    logic        dvalid_q;
    logic [1:0]  didx_q;
    aid_byte_t   dbyte_q;
    logic        dlast_q;
    logic [15:0] word [4];
    logic [3:0]  upd;

    // ===========================================================
    // decode
    wire [3:0] active;
    wire [3:0] opt_hit;
    wire [3:0] func_hit;
    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_chan
            assign active[g]   = (func_q[g] != `AID_FUNC_OFF);
            assign opt_hit[g]  = reg_addr_in == `AID_OFS_OPT0 + 8'(g);
            assign func_hit[g] = reg_addr_in == `AID_OFS_FUNC0 + 8'(g);
            aid_chan_filter u_filt
            (
                .core_clk_in     (core_clk_in),
                .reset_in        (reset_in),
                .sample_valid_in (conv_done_in && state_q == ST_BUSY && chan_q == 2'(g) &&
                                  active[g]),
                .sample_in       (conv_data_in),
                .option_in       (opt_q[g]),
                .value_out       (word[g]),
                .update_out      (upd[g])
            );
        end
    endgenerate

    // round robin over active channels splits the rate between them
    function automatic logic [1:0] next_chan(input logic [1:0] last, input logic [3:0] act);
        logic [1:0] c;
        next_chan = last;
        for (int i = 4; i >= 1; i--)
        begin
            c = last + 2'(i);
            if (act[c])
                next_chan = c;
        end
    endfunction : next_chan

    wire        any_active = |active;
    wire [1:0]  pick       = next_chan(chan_q, active);
    wire [2:0]  pick_rate  = aid_rate_code(opt_q[pick]);
    wire        alarm_en   = alarm_q[`AID_ALARM_BIT];
    wire        chan_any   = |chan_error_in;
    wire        err_now    = module_fault_in || ext_error_in || chan_any;
    wire        err_evt    = err_now && !err_prev_q;
    wire        wr_alarm   = reg_wr_in && reg_addr_in == `AID_OFS_ALARM;
    wire        wr_irq_en  = reg_wr_in && reg_addr_in == `AID_OFS_IRQ_EN;
    wire        wr_clr     = reg_wr_in && reg_addr_in == `AID_OFS_IRQ_CLR;
    wire [1:0]  clr_bits   = wr_clr ? reg_wdata_in[1:0] : 2'h0;
    wire        diag_clr   = clr_bits[`AID_IRQ_DIAG] && !err_now;
    wire        dstart     = err_evt && alarm_en && !dvalid_q;
    wire        dstep      = dvalid_q && diag_ready_in;
    wire [7:0]  dsel_ofs   = reg_addr_in - `AID_OFS_DATA0;
    wire [15:0] rd_word    = word[dsel_ofs[2:1]];
    wire        is_data    = reg_addr_in >= `AID_OFS_DATA0 &&
                             reg_addr_in < `AID_OFS_DATA0 + 8'h08;
    wire        is_opt     = |opt_hit;
    wire        is_func    = |func_hit;
    wire [1:0]  opt_idx    = 2'(reg_addr_in - `AID_OFS_OPT0);
    wire [1:0]  func_idx   = 2'(reg_addr_in - `AID_OFS_FUNC0);
    wire [7:0]  new_diag0  = {4'h0, chan_any, ext_error_in, 1'b0, module_fault_in};
    wire [7:0]  new_diag1  = {3'h0, chan_any, `AID_CLASS_ANALOG};

    aid_byte_t rd_mux;
    always_comb
    begin
        rd_mux = 8'h00;
        if (reg_addr_in == `AID_OFS_DIAG0)
            rd_mux = diag0_q;
        else if (reg_addr_in == `AID_OFS_DIAG1)
            rd_mux = diag1_q;
        else if (is_opt)
            rd_mux = opt_q[opt_idx];
        else if (is_func)
            rd_mux = func_q[func_idx];
        else if (reg_addr_in == `AID_OFS_ALARM)
            rd_mux = alarm_q;
        else if (is_data)
            rd_mux = dsel_ofs[0] ? rd_word[7:0] : rd_word[15:8];
        else if (reg_addr_in == `AID_OFS_IRQ_ST)
            rd_mux = {6'h00, irq_st_q};
        else if (reg_addr_in == `AID_OFS_IRQ_EN)
            rd_mux = {6'h00, irq_en_q};
        else if (reg_addr_in == `AID_OFS_ACTIVE)
            rd_mux = {4'h0, active};
    end

    // ===========================================================
    // conversion scheduler
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: if (any_active) state_d = ST_WAIT;
            ST_WAIT:
                // a channel switched off while waiting gives up its turn
                if (!active[chan_q])
                    state_d = ST_IDLE;
                else if (tmr_q == 32'h0)
                    state_d = ST_BUSY;
            ST_BUSY: if (conv_done_in) state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= ST_IDLE;
            tmr_q   <= 32'h0;
            chan_q  <= 2'h3;
            start_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            start_q <= state_q == ST_WAIT && tmr_q == 32'h0 && active[chan_q];
            if (state_q == ST_IDLE && any_active)
            begin
                chan_q <= pick;
                tmr_q  <= CONV_CYC[pick_rate] - 32'h1;
            end
            else if (state_q == ST_WAIT && tmr_q != 32'h0)
                tmr_q <= tmr_q - 32'h1;
        end
    end

    // ===========================================================
    // parameter registers
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            for (int i = 0; i < 4; i++)
            begin
                opt_q[i]  <= `AID_OPT_RST;
                func_q[i] <= `AID_FUNC_RST;
            end
            alarm_q  <= `AID_ALARM_RST;
            irq_en_q <= 2'h0;
        end
        else
        begin
            if (reg_wr_in && is_opt)
                opt_q[opt_idx] <= reg_wdata_in;
            // zero leaves the stored function untouched
            if (reg_wr_in && is_func && reg_wdata_in != `AID_FUNC_KEEP)
                func_q[func_idx] <= reg_wdata_in;
            if (wr_alarm)
                alarm_q <= reg_wdata_in;
            if (wr_irq_en)
                irq_en_q <= reg_wdata_in[1:0];
        end
    end

    // ===========================================================
    // diagnostics, indicators and interrupt
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            diag0_q    <= 8'h00;
            diag1_q    <= 8'h00;
            chan_lat_q <= 4'h0;
            err_prev_q <= 1'b0;
            led_q      <= 4'h0;
            dvalid_q   <= 1'b0;
            didx_q     <= 2'h0;
            dbyte_q    <= 8'h00;
            dlast_q    <= 1'b0;
            irq_st_q   <= 2'h0;
            irq_q      <= 1'b0;
            rdata_q    <= 8'h00;
        end
        else
        begin
            err_prev_q <= err_now;
            if (err_evt)
            begin
                diag0_q    <= new_diag0;
                diag1_q    <= new_diag1;
                chan_lat_q <= chan_error_in;
            end
            else if (diag_clr)
            begin
                diag0_q    <= 8'h00;
                diag1_q    <= 8'h00;
                chan_lat_q <= 4'h0;
            end
            led_q <= chan_error_in | chan_lat_q;
            if (dstart)
            begin
                dvalid_q <= 1'b1;
                didx_q   <= 2'h0;
                dbyte_q  <= new_diag0;
                dlast_q  <= 1'b0;
            end
            else if (dstep)
            begin
                dvalid_q <= didx_q != 2'h3;
                didx_q   <= didx_q + 2'h1;
                dbyte_q  <= (didx_q == 2'h0) ? diag1_q : 8'h00;
                dlast_q  <= didx_q == 2'h2;
            end
            // a set in the clearing cycle wins over the clear
            irq_st_q[`AID_IRQ_DIAG] <= dstart || (irq_st_q[`AID_IRQ_DIAG] && !clr_bits[0]);
            irq_st_q[`AID_IRQ_DATA] <= |upd || (irq_st_q[`AID_IRQ_DATA] && !clr_bits[1]);
            irq_q   <= |(irq_st_q & irq_en_q);
            rdata_q <= reg_rd_in ? rd_mux : 8'h00;
        end
    end

    // ===========================================================
    // outputs
    assign reg_rdata_out          = rdata_q;
    assign conv_start_out         = start_q;
    assign conv_chan_out          = chan_q;
    assign diag_valid_out         = dvalid_q;
    assign diag_data_out          = dbyte_q;
    assign diag_last_out          = dlast_q;
    assign channel_error_leds_out = led_q;
    assign irq_out                = irq_q;

    // ===========================================================
    // assertions
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_dstart;
        $rose(dvalid_q) && diag_ready_in;
    endsequence
    sequence s_drain;
        diag_ready_in [*2];
    endsequence

    property p_diag_len;
        s_dstart ##1 s_drain |=> diag_last_out && !$past(diag_last_out);
    endproperty
    a_diag_len: assert property (p_diag_len) else $error("record not four bytes");

    property p_diag_first;
        s_dstart |-> diag_data_out == diag0_q ##1 diag_data_out == diag1_q;
    endproperty
    a_diag_first: assert property (p_diag_first) else $error("record head wrong");

    property p_diag_tail;
        dvalid_q && didx_q[1] |-> diag_data_out == 8'h00;
    endproperty
    a_diag_tail: assert property (p_diag_tail) else $error("record tail not zero");

    property p_alarm_gate;
        $rose(dvalid_q) |-> $past(alarm_en);
    endproperty
    a_alarm_gate: assert property (p_alarm_gate) else $error("alarm sent while inhibited");

    property p_diag_fields;
        err_evt |=> diag1_q[3:0] == 4'h5 && diag0_q[1] == 1'b0 && diag0_q[3] == $past(chan_any);
    endproperty
    a_diag_fields: assert property (p_diag_fields) else $error("diag fields wrong");

    property p_led;
        chan_error_in[0] |=> channel_error_leds_out[0];
    endproperty
    a_led: assert property (p_led) else $error("channel light not lit");

    property p_active_only;
        conv_start_out |-> $past(active[chan_q], 2);
    endproperty
    a_active_only: assert property (p_active_only) else $error("off channel converted");

    property p_period;
        state_q == ST_IDLE && any_active |=> tmr_q == CONV_CYC[$past(pick_rate)] - 32'h1;
    endproperty
    a_period: assert property (p_period) else $error("conversion period wrong");

    property p_irq;
        |(irq_st_q & irq_en_q) |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule : aid_option_diag

/* dv/aid_conv_model.sv */
// converter front end model answering start pulses
`timescale 1ns/1ps
module aid_conv_model
(
    // clock and reset
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // converter side
    input  wire logic        start_in,
    input  wire logic [1:0]  chan_in,
    output logic             done_out,
    output logic [15:0]      data_out,
    // bench control
    input  wire logic        slow_in,
    input  wire logic [63:0] levels_in
);
    // ==========================================
    // one conversion at a time
    logic [2:0]  wait_q;
    logic        busy_q;
    logic [15:0] val_q;
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            busy_q   <= 1'b0;
            wait_q   <= 3'h0;
            val_q    <= 16'h0000;
            done_out <= 1'b0;
            data_out <= 16'hA5A5;
        end
        else
        begin
            done_out <= 1'b0;
            // toggles outside done so a stale word never passes for valid
            data_out <= ~data_out;
            if (start_in)
            begin
                busy_q <= 1'b1;
                wait_q <= slow_in ? 3'h7 : 3'h0;
                val_q  <= levels_in[chan_in*16 +: 16];
            end
            else if (busy_q && wait_q == 3'h0)
            begin
                busy_q   <= 1'b0;
                done_out <= 1'b1;
                data_out <= val_q;
            end
            else if (busy_q)
                wait_q <= wait_q - 3'h1;
        end
    end
endmodule : aid_conv_model

/* dv/analog_input_option_diag_bench.sv */
// self-checking bench for the option and diagnostic block
`timescale 1ns/1ps
`include "aid_consts.svh"
module analog_input_option_diag_bench;
    import aid_pkg::*;
    // ==========================================
    // signals
    logic        core_clk = 1'b0;
    logic        reset, wr, rd, start, done, fault, ext, dvalid, dlast, dready, irq, slow;
    logic [7:0]  addr;
    aid_byte_t   wdata, rdata, ddata;
    logic [1:0]  chan;
    logic [15:0] cdata;
    logic [3:0]  cerr, leds;
    logic [63:0] levels;
    int          num_errors = 0;
    int          checks = 0;
    int          cycles = 0;

    always #4 core_clk = ~core_clk;

    aid_option_diag #(.CONV_CYC('{20, 24, 28, 32, 36, 40, 44, 48})) aid_option_diag_inst
    (
        .core_clk_in(core_clk), .reset_in(reset), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .conv_start_out(start), .conv_chan_out(chan), .conv_done_in(done),
        .conv_data_in(cdata), .module_fault_in(fault), .ext_error_in(ext),
        .chan_error_in(cerr), .diag_valid_out(dvalid), .diag_data_out(ddata),
        .diag_last_out(dlast), .diag_ready_in(dready), .channel_error_leds_out(leds),
        .irq_out(irq)
    );

    aid_conv_model aid_conv_model_inst
    (
        .core_clk_in(core_clk), .reset_in(reset), .start_in(start), .chan_in(chan),
        .done_out(done), .data_out(cdata), .slow_in(slow), .levels_in(levels)
    );

    // ==========================================
    // helpers
    task automatic wrap_up();
        $display("TB: errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    task automatic wr_reg(input logic [7:0] a, input aid_byte_t d);
        @(posedge core_clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a, output aid_byte_t d);
        @(posedge core_clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic rd_word(input int n, output logic [15:0] w);
        aid_byte_t h, l;
        rd_reg(8'(`AID_OFS_DATA0 + 2 * n), h);
        rd_reg(8'(`AID_OFS_DATA0 + 2 * n + 1), l);
        w = {h, l};
    endtask : rd_word

    task automatic rd_chk(input logic [7:0] a, input aid_byte_t e, input string what);
        aid_byte_t d;
        rd_reg(a, d);
        chk(16'(d), 16'(e), what);
    endtask : rd_chk

    // unlisted rate codes fall back to code 0000
    function automatic logic [15:0] exp_word(input logic [3:0] c, input logic [15:0] s);
        case (c)
            4'h2: exp_word = s & 16'hFFFE;
            4'h3: exp_word = s & 16'hFFFC;
            4'h4: exp_word = s & 16'hFFF0;
            4'h5: exp_word = s & 16'hFFC0;
            default: exp_word = s;
        endcase
    endfunction : exp_word

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            num_errors++;
            $display("[ERR] %0t run hung", $time);
            wrap_up();
        end
    end

    // ==========================================
    // tests
    initial
    begin
        logic [15:0] w, w1;
        aid_byte_t   got [4];
        logic [3:0]  lastv;
        int          i, n;
        void'($urandom(32'h4755C2A8));
        reset = 1'b1; wr = 1'b0; rd = 1'b0; addr = 8'h00; wdata = 8'h00;
        fault = 1'b0; ext = 1'b0; cerr = 4'h0; dready = 1'b0; slow = 1'b0;
        levels = 64'h0;
        idle(2);
        reset <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            rd_chk(8'(`AID_OFS_OPT0 + i), 8'h00, "option reset");
            rd_chk(8'(`AID_OFS_FUNC0 + i), 8'h28, "function reset");
        end
        rd_chk(`AID_OFS_ALARM, 8'h00, "alarm reset");
        rd_chk(`AID_OFS_DIAG2, 8'h00, "diag byte 2");
        rd_chk(`AID_OFS_DIAG3, 8'h00, "diag byte 3");
        rd_chk(8'h05, 8'h00, "unmapped read");
        $display("test reset values done");
        for (i = 0; i < 10; i++)
        begin
            levels <= {$urandom, $urandom};
            slow   <= i[0];
            wr_reg(`AID_OFS_OPT0, 8'(i));
            idle(600);
            rd_word(0, w);
            chk(w, exp_word(4'(i), levels[15:0]), "rate code word");
            rd_word(3, w);
            chk(w, levels[63:48], "channel 3 word");
        end
        $display("test rate codes done");
        wr_reg(8'(`AID_OFS_FUNC0 + 1), 8'hFF);
        wr_reg(`AID_OFS_FUNC0, 8'h00);
        rd_chk(`AID_OFS_ACTIVE, 8'h0D, "active mask");
        rd_chk(`AID_OFS_FUNC0, 8'h28, "function keep");
        rd_word(1, w1);
        levels <= {$urandom, $urandom};
        idle(600);
        rd_word(1, w);
        chk(w, w1, "off channel frozen");
        rd_word(2, w);
        chk(w, levels[47:32], "other channel runs");
        $display("test channel off done");
        fault <= 1'b1;
        for (i = 0; i < 20; i++)
        begin
            @(posedge core_clk);
            chk(16'(dvalid), 16'h0, "record while inhibited");
        end
        fault <= 1'b0;
        idle(2);
        wr_reg(`AID_OFS_IRQ_CLR, 8'h01);
        wr_reg(`AID_OFS_ALARM, 8'h40);
        wr_reg(`AID_OFS_IRQ_EN, 8'h01);
        fault <= 1'b1;
        ext   <= 1'b1;
        cerr  <= 4'h4;
        i = 0;
        n = 0;
        lastv = 4'h0;
        // sink stalls at random while the record drains
        while (i < 4 && n < 200)
        begin
            @(posedge core_clk);
            if (dvalid && dready)
            begin
                got[i]   = ddata;
                lastv[i] = dlast;
                i++;
            end
            dready <= 1'($urandom);
            n++;
        end
        dready <= 1'b0;
        chk(16'(got[0]), 16'h0D, "record byte 0");
        chk(16'(got[1]), 16'h15, "record byte 1");
        chk({got[3], got[2]}, 16'h0, "record bytes 2 3");
        chk(16'(lastv), 16'h8, "last flag");
        for (i = 0; i < 10; i++)
        begin
            @(posedge core_clk);
            chk(16'(dvalid), 16'h0, "no fifth byte");
        end
        chk(16'(leds), 16'h4, "red light on");
        chk(16'(irq), 16'h1, "irq raised");
        rd_chk(`AID_OFS_DIAG0, 8'h0D, "status byte");
        rd_chk(`AID_OFS_DIAG1, 8'h15, "class byte");
        wr_reg(`AID_OFS_IRQ_EN, 8'h00);
        idle(2);
        chk(16'(irq), 16'h0, "irq masked");
        wr_reg(`AID_OFS_IRQ_EN, 8'h01);
        fault <= 1'b0;
        ext   <= 1'b0;
        cerr  <= 4'h0;
        idle(2);
        wr_reg(`AID_OFS_IRQ_CLR, 8'h01);
        idle(2);
        chk(16'(irq), 16'h0, "irq cleared");
        chk(16'(leds), 16'h0, "red light off");
        rd_chk(`AID_OFS_DIAG0, 8'h00, "status cleared");
        $display("test diagnostics done");
        for (n = 1; n < 3; n++)
        begin
            wr_reg(8'(`AID_OFS_FUNC0 + 1), 8'hFF);
            rd_word(1, w1);
            wr_reg(8'(`AID_OFS_OPT0 + 1), 8'(n << 4));
            wr_reg(8'(`AID_OFS_FUNC0 + 1), 8'h28);
            i = 0;
            while (i < 6)
            begin
                @(posedge core_clk);
                levels <= {$urandom, $urandom};
                if (done && chan == 2'h1)
                begin
                    if (i % (3 * n) < 2 * n)
                        w1 = cdata;
                    i++;
                end
            end
            rd_word(1, w);
            chk(w, w1, "selection word");
            w1 = 16'($urandom) & 16'h3FFF;
            for (i = 0; i < 3; i++)
            begin
                wr_reg(8'(`AID_OFS_OPT0 + 1), i ? 8'(n << 6) : 8'h00);
                levels[31:16] <= w1 + (i ? 16'(8 * n + i - 1) : 16'h0);
                idle(300);
                rd_word(1, w);
                chk(w, w1 + (i > 1 ? 16'(8 * n + 1) : 16'h0), "envelope word");
            end
        end
        $display("test filters done");
        wrap_up();
    end
endmodule : analog_input_option_diag_bench
